// >>> adc_cal_defines.vh
// register offsets, reset values and field positions for the adc repeat, buffer and calibration bank
`ifndef ADC_CAL_DEFINES_VH
`define ADC_CAL_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_REPEAT_CTRL 16'h21f0
`define ADDR_UNLOCK_KEY 16'h2230
`define ADDR_OFS_HSTI 16'h2234
`define ADDR_GAIN_TEMP 16'h2238
`define ADDR_OFS_TEMP 16'h223c
`define ADDR_GAIN_AUX1 16'h2240
`define ADDR_OFS_AUX1 16'h2244
`define ADDR_GAIN_AUX1P5 16'h2270
`define ADDR_GAIN_AUX2 16'h2274
`define ADDR_GAIN_AUX4 16'h2278
`define ADDR_GAIN_HSTI 16'h2284
`define ADDR_OFS_LPTI 16'h2288
`define ADDR_GAIN_LPTI 16'h228c
`define ADDR_GAIN_AUX9 16'h2298
`define ADDR_OFS_AUX2 16'h22c8
`define ADDR_OFS_AUX1P5 16'h22cc
`define ADDR_OFS_AUX9 16'h22d0
`define ADDR_OFS_AUX4 16'h22d4
`define ADDR_BUF_CONFIG 16'h238c
`define ADDR_CONV_STATUS 16'h2400
// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define RST_REPEAT_CTRL 32'h00000160
`define RST_BUF_CONFIG 32'h005f3d00
`define RST_OFS_CAL 15'h0000
`define RST_GAIN_CAL 15'h4000
`define RST_UNLOCK_KEY 32'h00000000
`define UNLOCK_KEY_VALUE 32'hde87a5af
// ----------------------------------------
// field positions
// ----------------------------------------
`define REP_EN_BIT 0
`define REP_CNT_LSB 4
`define REP_CNT_MSB 11
`define BUF_PD_LSB 4
`define BUF_PD_MSB 8
`define BUF_CHOP_LSB 0
`define BUF_CHOP_MSB 3
`define BUF_HIGH_MSB 31
`define BUF_HIGH_LSB 9
`define CAL_MSB 14
`define PD_NEG_FE_BIT 4
`define PD_POS_FE_BIT 5
`define PD_PGA_BIT 6
`define PD_ADC_BUF_BIT 7
`define PD_OFS_BUF_BIT 8
`define CHOP_FE_BIT 0
`define CHOP_PGA_BIT 1
`define CHOP_ADC_BUF_BIT 2
`define CHOP_OFS_BUF_BIT 3
`define RST_PD 5'h10
`define RST_CHOP 4'h0
`define NUM_CAL 16
`endif

// >>> adc_cal_regs.v
// register bank for the adc repeat control, buffer configuration and calibration data
`timescale 1ns/1ps
`include "adc_cal_defines.vh"

module adc_cal_regs #(
  parameter CAL_W = 15
) (
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  input wire mclk,
  input wire rst_b,
  input wire [15:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg [1:0] response,
  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  input wire conv_start,
  input wire conv_done,
  output reg repeat_active,
  output reg conv_request,
  // ----------------------------------------
  // analog controls
  // ----------------------------------------
  output reg [4:0] amplifier_power_down,
  output reg [3:0] chop_disable,
  output reg [CAL_W*`NUM_CAL-1:0] cal_values
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // every register keeps its full 32-bit image so a read needs no extra shaping;
  // calibration slots only hold the fifteen value bits
  reg [31:0] repeat_ctrl_reg;
  reg [31:0] buf_config_reg;
  reg [31:0] unlock_key_reg;
  reg [CAL_W-1:0] cal_reg [0:`NUM_CAL-1];
  reg [8:0] remain_reg;
  reg ack_reg;
  wire [31:0] wmask;
  wire unlocked;
  wire req;
  reg [4:0] cal_idx;
  reg [31:0] rdata_next;
  reg hit_next;
  integer i;
  wire write_hit;
  wire [31:0] rep_merged;
  wire [31:0] buf_merged;
  wire [31:0] key_merged;
  wire [31:0] cal_merged;
  wire [31:0] status_word;

  // ----------------------------------------
  // calibration slot numbers
  // ----------------------------------------
  // offsets fill slots 0..7 and gains 8..15 in the same channel order,
  // so a gain slot is always its offset slot plus eight
  localparam [4:0] SLOT_OFS_LPTI = 5'h00;
  localparam [4:0] SLOT_OFS_HSTI = 5'h01;
  localparam [4:0] SLOT_OFS_AUX1 = 5'h02;
  localparam [4:0] SLOT_OFS_AUX1P5 = 5'h03;
  localparam [4:0] SLOT_OFS_AUX2 = 5'h04;
  localparam [4:0] SLOT_OFS_AUX4 = 5'h05;
  localparam [4:0] SLOT_OFS_AUX9 = 5'h06;
  localparam [4:0] SLOT_OFS_TEMP = 5'h07;
  localparam [4:0] SLOT_GAIN_LPTI = 5'h08;
  localparam [4:0] SLOT_GAIN_HSTI = 5'h09;
  localparam [4:0] SLOT_GAIN_AUX1 = 5'h0a;
  localparam [4:0] SLOT_GAIN_AUX1P5 = 5'h0b;
  localparam [4:0] SLOT_GAIN_AUX2 = 5'h0c;
  localparam [4:0] SLOT_GAIN_AUX4 = 5'h0d;
  localparam [4:0] SLOT_GAIN_AUX9 = 5'h0e;
  localparam [4:0] SLOT_GAIN_TEMP = 5'h0f;
  localparam [4:0] NO_SLOT = 5'h1f;

  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign unlocked = (unlock_key_reg == `UNLOCK_KEY_VALUE);
  assign req = (read | write) & ~ack_reg;

  // index 0..7 offsets, 8..15 gains; 31 means not a calibration address
  // one offset and gain pair per channel
  function [4:0] cal_index;
    input [15:0] a;
    begin
      case (a)
        `ADDR_OFS_LPTI: cal_index = SLOT_OFS_LPTI;
        `ADDR_OFS_HSTI: cal_index = SLOT_OFS_HSTI;
        `ADDR_OFS_AUX1: cal_index = SLOT_OFS_AUX1;
        `ADDR_OFS_AUX1P5: cal_index = SLOT_OFS_AUX1P5;
        `ADDR_OFS_AUX2: cal_index = SLOT_OFS_AUX2;
        `ADDR_OFS_AUX4: cal_index = SLOT_OFS_AUX4;
        `ADDR_OFS_AUX9: cal_index = SLOT_OFS_AUX9;
        `ADDR_OFS_TEMP: cal_index = SLOT_OFS_TEMP;
        `ADDR_GAIN_LPTI: cal_index = SLOT_GAIN_LPTI;
        `ADDR_GAIN_HSTI: cal_index = SLOT_GAIN_HSTI;
        `ADDR_GAIN_AUX1: cal_index = SLOT_GAIN_AUX1;
        `ADDR_GAIN_AUX1P5: cal_index = SLOT_GAIN_AUX1P5;
        `ADDR_GAIN_AUX2: cal_index = SLOT_GAIN_AUX2;
        `ADDR_GAIN_AUX4: cal_index = SLOT_GAIN_AUX4;
        `ADDR_GAIN_AUX9: cal_index = SLOT_GAIN_AUX9;
        `ADDR_GAIN_TEMP: cal_index = SLOT_GAIN_TEMP;
        default: cal_index = NO_SLOT;
      endcase
    end
  endfunction

  // ----------------------------------------
  // byte lane merge
  // ----------------------------------------
  // new data where a lane is enabled, old data elsewhere
  function [31:0] merge;
    input [31:0] new_word;
    input [31:0] old_word;
    input [31:0] mask;
    begin
      merge = (new_word & mask) | (old_word & ~mask);
    end
  endfunction

  // ----------------------------------------
  // merged write images
  // ----------------------------------------
  // each register sees its own merged image; only its write strobe picks it up
  // calibration slots are widened to a word so one merge serves them all
  assign rep_merged = merge(writedata, repeat_ctrl_reg, wmask);
  assign buf_merged = merge(writedata, buf_config_reg, wmask);
  assign key_merged = merge(writedata, unlock_key_reg, wmask);
  assign cal_merged = merge(writedata, {{(32-CAL_W){1'b0}}, cal_reg[cal_idx[3:0]]}, wmask);

  // ----------------------------------------
  // run status
  // ----------------------------------------
  // read-only view of the sequencer: bit 0 busy, bits 9:1 conversions still owed
  assign status_word = {22'h000000, remain_reg, repeat_active};

  // ----------------------------------------
  // run length
  // ----------------------------------------
  // count n asks for n conversions, all ones asks for 256
  function [8:0] run_length;
    input [31:0] ctrl;
    begin
      if (!ctrl[`REP_EN_BIT])
        run_length = 9'h001;
      else if (ctrl[`REP_CNT_MSB:`REP_CNT_LSB] == 8'hff)
        run_length = 9'h100;
      else
        run_length = {1'b0, ctrl[`REP_CNT_MSB:`REP_CNT_LSB]};
    end
  endfunction

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // unmapped addresses read zero and flag a decode error in the response;
  // the status word sits outside the calibration slots so it never aliases one
  always @* begin
    cal_idx = cal_index(address);
    hit_next = 1'b1;
    rdata_next = 32'h00000000;
    if (cal_idx != 5'h1f) begin
      // low fifteen bits, upper bits read zero
      rdata_next = {{(32-CAL_W){1'b0}}, cal_reg[cal_idx[3:0]]};
    end else begin
      case (address)
        `ADDR_REPEAT_CTRL: rdata_next = repeat_ctrl_reg;
        `ADDR_BUF_CONFIG: rdata_next = buf_config_reg;
        `ADDR_UNLOCK_KEY: rdata_next = unlock_key_reg;
        `ADDR_CONV_STATUS: rdata_next = status_word;
        default: hit_next = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // bus slave: one wait cycle, answer on the second edge
  // ----------------------------------------
  // ack_reg masks the request on the answer edge, so a master that holds its
  // strobe through that edge is never served twice; back to back costs two cycles
  // readdata and response stand until the next request is taken
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      response <= 2'h0;
    end else begin
      ack_reg <= req;
      waitrequest <= ~req;
      if (req) begin
        readdata <= read ? rdata_next : 32'h00000000;
        // unmapped address answers with decode error
        response <= hit_next ? 2'h0 : 2'h3;
      end
    end
  end

  // ----------------------------------------
  // register writes, taken with the acknowledge
  // ----------------------------------------
  // a write lands on the edge that raises the acknowledge; the master still holds
  // address and data through the answer edge, so committing here loses nothing
  assign write_hit = req & write;

  // ----------------------------------------
  // repeat control
  // ----------------------------------------
  // only bit 0 and bits 11:4 hold state; the reserved bits keep reading zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      repeat_ctrl_reg <= `RST_REPEAT_CTRL;
    end else if (write_hit && address == `ADDR_REPEAT_CTRL) begin
      repeat_ctrl_reg[`REP_EN_BIT] <= rep_merged[`REP_EN_BIT];
      // count field, zero taken as written
      repeat_ctrl_reg[`REP_CNT_MSB:`REP_CNT_LSB] <= rep_merged[`REP_CNT_MSB:`REP_CNT_LSB];
    end
  end

  // ----------------------------------------
  // buffer configuration
  // ----------------------------------------
  // bits 31:9 keep their reset pattern and ignore writes
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      buf_config_reg <= `RST_BUF_CONFIG;
    end else if (write_hit && address == `ADDR_BUF_CONFIG) begin
      buf_config_reg[`BUF_PD_MSB:`BUF_PD_LSB] <= buf_merged[`BUF_PD_MSB:`BUF_PD_LSB];
      buf_config_reg[`BUF_CHOP_MSB:`BUF_CHOP_LSB] <= buf_merged[`BUF_CHOP_MSB:`BUF_CHOP_LSB];
    end
  end

  // ----------------------------------------
  // unlock key
  // ----------------------------------------
  // the unlock is a level: any later write of another value locks the bank again
  // a partial-lane write can also build the key, one byte at a time
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_key_reg <= `RST_UNLOCK_KEY;
    end else if (write_hit && address == `ADDR_UNLOCK_KEY) begin
      unlock_key_reg <= key_merged;
    end
  end

  // ----------------------------------------
  // calibration array
  // ----------------------------------------
  // a locked write is still answered ok so software sees no bus error; the data is dropped
  // upper bits of the write data never reach the slot
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `NUM_CAL; i = i + 1) begin
        cal_reg[i] <= (i < 8) ? `RST_OFS_CAL : `RST_GAIN_CAL;
      end
    end else if (write_hit && cal_idx != NO_SLOT) begin
      if (unlocked) begin
        cal_reg[cal_idx[3:0]] <= cal_merged[CAL_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // repeat sequencer
  // ----------------------------------------
  // a zero count is not guarded; it ends after a single conversion
  // a start while a run is busy is ignored, and so is a done while idle;
  // the conversion engine must answer each request with exactly one done pulse,
  // otherwise the run ends early or hangs waiting
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      remain_reg <= 9'h000;
      repeat_active <= 1'b0;
      conv_request <= 1'b0;
    end else begin
      conv_request <= 1'b0;
      if (!repeat_active) begin
        if (conv_start) begin
          repeat_active <= 1'b1;
          conv_request <= 1'b1;
          // count only when enabled, else one conversion
          remain_reg <= run_length(repeat_ctrl_reg);
        end
      end else if (conv_done) begin
        if (remain_reg <= 9'h001) begin
          remain_reg <= 9'h000;
          repeat_active <= 1'b0;
        end else begin
          remain_reg <= remain_reg - 9'h001;
          conv_request <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // analog controls
  // ----------------------------------------
  // outputs lag the registers by one cycle so every top-level output is a flop
  genvar g;
  generate
    for (g = 0; g < `NUM_CAL; g = g + 1) begin : cal_out
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
          cal_values[g*CAL_W +: CAL_W] <= (g < 8) ? `RST_OFS_CAL : `RST_GAIN_CAL;
        else
          cal_values[g*CAL_W +: CAL_W] <= cal_reg[g];
      end
    end
  endgenerate

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      amplifier_power_down <= `RST_PD;
      chop_disable <= `RST_CHOP;
    end else begin
      // one bit per amplifier, 1 = off
      amplifier_power_down[0] <= buf_config_reg[`PD_NEG_FE_BIT];
      amplifier_power_down[1] <= buf_config_reg[`PD_POS_FE_BIT];
      amplifier_power_down[2] <= buf_config_reg[`PD_PGA_BIT];
      amplifier_power_down[3] <= buf_config_reg[`PD_ADC_BUF_BIT];
      amplifier_power_down[4] <= buf_config_reg[`PD_OFS_BUF_BIT];
      // one bit per chop stage, 1 = chop off
      chop_disable[0] <= buf_config_reg[`CHOP_FE_BIT];
      chop_disable[1] <= buf_config_reg[`CHOP_PGA_BIT];
      chop_disable[2] <= buf_config_reg[`CHOP_ADC_BUF_BIT];
      chop_disable[3] <= buf_config_reg[`CHOP_OFS_BUF_BIT];
    end
  end

endmodule // adc_cal_regs

// >>> adc_cal_regs_monitor.sv
// bus, sequencer and output-stability assertions for the adc calibration register bank
`timescale 1ns/1ps
`include "adc_cal_defines.vh"
module adc_cal_regs_monitor #(
  parameter CAL_W = 15
) (
  input wire mclk,
  input wire rst_b,
  input wire read,
  input wire write,
  input wire waitrequest,
  input wire [1:0] response,
  input wire conv_start,
  input wire conv_done,
  input wire repeat_active,
  input wire conv_request,
  input wire [4:0] amplifier_power_down,
  input wire [3:0] chop_disable,
  input wire [CAL_W*`NUM_CAL-1:0] cal_values
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("request not answered after one wait edge");
  property p_one_low; !waitrequest |=> waitrequest[*2] or (waitrequest ##1 !waitrequest); endproperty
  a_one_low: assert property (p_one_low) else $error("waitrequest low longer than one cycle");
  property p_resp; !waitrequest |-> response == 2'h0 || response == 2'h3; endproperty
  a_resp: assert property (p_resp) else $error("illegal response code");
  property p_chop; $changed(chop_disable) |-> $past(write); endproperty
  a_chop: assert property (p_chop) else $error("chop bits changed without a write");
  property p_pd; $changed(amplifier_power_down) |-> $past(write); endproperty
  a_pd: assert property (p_pd) else $error("power-down bits changed without a write");
  property p_cal; $changed(cal_values) |-> $past(write); endproperty
  a_cal: assert property (p_cal) else $error("calibration value changed without a write");
  property p_start; $rose(repeat_active) |-> conv_request && $past(conv_start); endproperty
  a_start: assert property (p_start) else $error("run began without start or request");
  property p_next; conv_request && !$rose(repeat_active) |-> $past(conv_done) && repeat_active; endproperty
  a_next: assert property (p_next) else $error("request without a finished conversion");
  property p_pulse; conv_request |=> !conv_request; endproperty
  a_pulse: assert property (p_pulse) else $error("conversion request wider than one cycle");
endmodule // adc_cal_regs_monitor
bind adc_cal_regs adc_cal_regs_monitor #(.CAL_W(CAL_W)) i_mon (.mclk(mclk), .rst_b(rst_b), .read(read),
  .write(write), .waitrequest(waitrequest), .response(response), .conv_start(conv_start), .conv_done(conv_done),
  .repeat_active(repeat_active), .conv_request(conv_request), .amplifier_power_down(amplifier_power_down),
  .chop_disable(chop_disable), .cal_values(cal_values));

// >>> adc_cal_regs_tb.sv
// self-checking testbench for the adc calibration register bank
`timescale 1ns/1ps
`include "adc_cal_defines.vh"
module adc_cal_regs_tb;
  logic mclk = 1'b0, rst_b = 1'b1, read = 1'b0, write = 1'b0, conv_start = 1'b0, conv_done = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [15:0] address = 16'h0000;
  logic [31:0] writedata = 32'h00000000, rdata;
  logic [1:0] rresp;
  wire [31:0] readdata;
  wire [1:0] response;
  wire waitrequest, repeat_active, conv_request;
  wire [4:0] amplifier_power_down;
  wire [3:0] chop_disable;
  wire [239:0] cal_values;
  int errors = 0, checks = 0, reqs = 0;
  // write flag, address, write data, expected read
  logic [80:0] rows [11] = '{{1'b0, 16'h21f0, 32'h0, 32'h160}, {1'b0, 16'h238c, 32'h0, 32'h5f3d00},
    {1'b1, 16'h21f0, 32'hffffffff, 32'hff1}, {1'b1, 16'h238c, 32'hffffffff, 32'h5f3dff},
    {1'b1, 16'h238c, 32'h5f3d04, 32'h5f3d04}, {1'b1, 16'h2288, 32'h7fff, 32'h0},
    {1'b1, 16'h2230, 32'hde87a5af, 32'hde87a5af}, {1'b1, 16'h2288, 32'hffffffff, 32'h7fff},
    {1'b1, 16'h2238, 32'h2000, 32'h2000}, {1'b1, 16'h2230, 32'h1, 32'h1}, {1'b1, 16'h2238, 32'h7fff, 32'h2000}};
  logic [15:0] zero_a [9] = '{16'h2230, 16'h2234, 16'h223c, 16'h2244, 16'h2288, 16'h22c8, 16'h22cc, 16'h22d0,
    16'h22d4};
  logic [15:0] gain_a [8] = '{16'h2238, 16'h2240, 16'h2270, 16'h2274, 16'h2278, 16'h2284, 16'h228c, 16'h2298};
  adc_cal_regs i_dut (.mclk(mclk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .conv_start(conv_start), .conv_done(conv_done), .repeat_active(repeat_active),
    .conv_request(conv_request), .amplifier_power_down(amplifier_power_down), .chop_disable(chop_disable),
    .cal_values(cal_values));
  always #20 mclk = ~mclk;
  // the far side answers every request one cycle later
  always @(posedge mclk) begin
    conv_done <= conv_request;
    if (conv_request === 1'b1) reqs <= reqs + 1;
  end
  task automatic close_out;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a; write <= w; read <= !w; writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rdata = readdata; rresp = response;
    read <= 1'b0; write <= 1'b0;
    @(posedge mclk);
    if (n >= 20) begin errors++; close_out(); end
  endtask
  task automatic run(input logic [31:0] ctrl, input int n);
    int k, base;
    bus(1'b1, `ADDR_REPEAT_CTRL, ctrl);
    base = reqs; k = 0;
    conv_start <= 1'b1;
    @(posedge mclk);
    conv_start <= 1'b0;
    do begin
      @(posedge mclk);
      k++;
    end while (repeat_active !== 1'b0 && k < 2000);
    repeat (2) @(posedge mclk);
    if (k >= 2000) begin errors++; close_out(); end
    cmp(32'(reqs - base), 32'(n));
  endtask
  initial begin
    // a real falling edge, so the asynchronous reset fires
    rst_b <= 1'b0;
    repeat (16) @(posedge mclk);
    cmp({waitrequest, 3'h0, chop_disable, 3'h0, amplifier_power_down}, 32'h8010);
    rst_b <= 1'b1;
    @(posedge mclk);
    foreach (zero_a[i]) begin bus(1'b0, zero_a[i], 32'h0); cmp(rdata, 32'h0); end
    foreach (gain_a[i]) begin bus(1'b0, gain_a[i], 32'h0); cmp(rdata, 32'h4000); end
    foreach (rows[i]) begin
      if (rows[i][80]) bus(1'b1, rows[i][79:64], rows[i][63:32]);
      bus(1'b0, rows[i][79:64], 32'h0);
      cmp({rdata[31:2], rresp}, {rows[i][31:2], 2'h0});
      cmp(rdata, rows[i][31:0]);
    end
    cmp({amplifier_power_down, chop_disable}, 32'h104);
    cmp(cal_values[14:0], 32'h7fff);
    cmp(cal_values[239:225], 32'h2000);
    bus(1'b1, `ADDR_BUF_CONFIG, 32'h15f);
    cmp({amplifier_power_down, chop_disable}, 32'h15f);
    bus(1'b0, 16'h2000, 32'h0);
    cmp(rresp, 2'h3);
    run(32'h31, 3);
    run(32'h30, 1);
    run(32'hff1, 256);
    run(32'h11, 1);
    bus(1'b0, `ADDR_CONV_STATUS, 32'h0);
    cmp(rdata, 32'h0);
    byteenable <= 4'h2;
    bus(1'b1, `ADDR_REPEAT_CTRL, 32'h00000a00);
    byteenable <= 4'hf;
    bus(1'b0, `ADDR_REPEAT_CTRL, 32'h0);
    cmp(rdata, 32'ha11);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp({amplifier_power_down, chop_disable}, 32'h100);
    rst_b <= 1'b1;
    @(posedge mclk);
    bus(1'b0, `ADDR_REPEAT_CTRL, 32'h0);
    cmp(rdata, 32'h160);
    close_out();
  end
endmodule // adc_cal_regs_tb
